//--- common/core_map.vh
// address map, region and opcode encodings and timing constants for the core
`ifndef CORE_MAP_VH
`define CORE_MAP_VH
`define IO_DIRECT_LAST 24'h00003F
`define IO_SPACE_LAST 24'h000FFF
`define EEP_WIN_FIRST 24'h001000
`define EEP_WIN_LAST 24'h001FFF
`define SRAM_FIRST 24'h002000
`define SRAM_LAST_DEF 24'h003FFF
`define BOOT_FIRST_DEF 24'h010000
`define TABLE_FIRST_DEF 24'h00F000
`define RESET_VECTOR 24'h000000
`define MUL_CYCLES 2
`define RGN_IO 3'h0
`define RGN_EEP 3'h1
`define RGN_SRAM 3'h2
`define RGN_EXT 3'h3
`define OP_NOP 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_AND 4'h3
`define OP_OR 4'h4
`define OP_XOR 4'h5
`define OP_LDI 4'h6
`define OP_INC 4'h7
`define OP_MUL 4'h8
`define OP_LDD 4'h9
`define OP_STD 4'hA
`define OP_IN 4'hB
`define OP_OUT 4'hC
`define OP_SPS 4'hD
`define OP_LPM 4'hE
`define OP_JMP 4'hF
`endif

//--- hdl/reg_file.v
// thirty-two 8-bit working registers, two read ports and a 16-bit write
`timescale 1ns/1ps
`include "core_map.vh"
module reg_file (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // read ports
    input wire [4:0] rd_a_sel,
    input wire [4:0] rd_b_sel,
    output wire [7:0] rd_a,
    output wire [7:0] rd_b,
    // pointer pairs x, y, z
    output wire [15:0] ptr_x,
    output wire [15:0] ptr_y,
    output wire [15:0] ptr_z,
    // write port, optional upper byte to sel+1
    input wire wr_en,
    input wire wr_wide,
    input wire [4:0] wr_sel,
    input wire [15:0] wr_data
);
    reg [7:0] regs_reg [0:31];
    wire [4:0] wr_hi_sel = wr_sel + 5'h01;
    // registers are written in one edge, read with no delay
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_reg
            always @(posedge clock) begin
                if (!rst_n) begin
                    regs_reg[gi] <= 8'h00;
                end else if (wr_en && wr_sel == gi) begin
                    regs_reg[gi] <= wr_data[7:0];
                end else if (wr_en && wr_wide && wr_hi_sel == gi) begin
                    regs_reg[gi] <= wr_data[15:8];
                end
            end
        end
    endgenerate
    assign rd_a = regs_reg[rd_a_sel];
    assign rd_b = regs_reg[rd_b_sel];
    assign ptr_x = {regs_reg[27], regs_reg[26]};
    assign ptr_y = {regs_reg[29], regs_reg[28]};
    assign ptr_z = {regs_reg[31], regs_reg[30]};
endmodule // reg_file

//--- hdl/mul_unit.v
// 8x8 multiplier, product ready after two cycles
`timescale 1ns/1ps
`include "core_map.vh"
module mul_unit (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // request
    input wire start,
    input wire [7:0] op_a,
    input wire [7:0] op_b,
    // answer
    output reg busy,
    output reg done,
    output reg [15:0] product
);
    reg [15:0] stage_reg;
    // first cycle forms the product, second hands it out
    always @(posedge clock) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            stage_reg <= 16'h0000;
            product <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                stage_reg <= op_a * op_b;
                busy <= 1'b1;
            end else if (busy) begin
                product <= stage_reg;
                done <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule // mul_unit

//--- hdl/cpu_core.v
// core: fetch/execute overlap, alu, data space decode, flash locks
//
// Notes on behaviour
// - fetch next word while current executes
// - thirty-two 8-bit single-cycle working registers
// - two register operands, one-cycle operation
// - reg-reg, reg-immediate, single-reg ops; flags
// - three register pairs form 16-bit pointers
// - separate 24-bit program and data buses
// - lowest 4KB of data is I/O
// - first 64 I/O reachable by direct I/O
// - 0x40-0xFFF only via data loads/stores
// - 0x1000-0x1FFF is the eeprom window
// - internal sram starts at 0x2000
// - instructions fetched only from program memory
// - self-program store works only from boot
// - application and boot sections have locks
// - application table has its own locks
// - multi-byte I/O moves as one value
// - fetch starts at address zero after reset
// - multiply 8x8 to 16 in two cycles
//
// instruction word: [31:28] op, [27:23] rd, [22:18] rr, [17:16] ptr sel,
// [15:8] immediate / io address low, [23:0] jump target for the jump op.
`timescale 1ns/1ps
`include "core_map.vh"
module cpu_core (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // program memory bus
    output wire [23:0] prog_addr,
    output wire prog_rd,
    input wire [31:0] prog_word,
    output reg [23:0] prog_wr_addr,
    output reg [15:0] prog_wr_data,
    output reg prog_wr,
    output reg [7:0] prog_rd_data,
    // flash lock straps: bit0 blocks write, bit1 blocks write and reads by code running in another section
    input wire [1:0] lock_app,
    input wire [1:0] lock_table,
    input wire [1:0] lock_boot,
    // section bounds
    input wire [23:0] table_first,
    input wire [23:0] boot_first,
    input wire [23:0] sram_last,
    // data memory bus
    output reg [23:0] data_addr,
    output reg [15:0] data_wdata,
    output reg [1:0] data_wbytes,
    output reg data_rd,
    output reg data_wr,
    output reg [2:0] data_region,
    input wire [15:0] data_rdata,
    // status
    output reg [7:0] flags,
    output reg lock_fault,
    output reg io_fault
);
    // decoding used at several places
    function [2:0] region_of;
        input [23:0] a;
        input [23:0] last;
        begin
            if (a <= `IO_SPACE_LAST) region_of = `RGN_IO;
            else if (a <= `EEP_WIN_LAST) region_of = `RGN_EEP;
            else if (a <= last) region_of = `RGN_SRAM;
            else region_of = `RGN_EXT;
        end
    endfunction
    // section of a program address: 0 app, 1 table, 2 boot
    function [1:0] section_of;
        input [23:0] a;
        input [23:0] tf;
        input [23:0] bf;
        begin
            if (a >= bf) section_of = 2'd2;
            else if (a >= tf) section_of = 2'd1;
            else section_of = 2'd0;
        end
    endfunction
    function [1:0] lock_of;
        input [1:0] sec;
        input [1:0] la;
        input [1:0] lt;
        input [1:0] lb;
        begin
            case (sec)
                2'd0: lock_of = la;
                2'd1: lock_of = lt;
                default: lock_of = lb;
            endcase
        end
    endfunction

    reg [23:0] pc_reg;
    reg [31:0] ir_reg;
    reg ir_valid_reg;
    reg [23:0] ir_pc_reg;
    reg stall_reg;
    reg [4:0] load_dst_reg;
    reg load_wide_reg;
    reg load_pend_reg;
    wire [3:0] op = ir_reg[31:28];
    wire [4:0] rd_sel = ir_reg[27:23];
    wire [4:0] rr_sel = ir_reg[22:18];
    wire [1:0] ptr_sel = ir_reg[17:16];
    wire [7:0] imm = ir_reg[15:8];
    wire [7:0] opa;
    wire [7:0] opb;
    wire [15:0] px;
    wire [15:0] py;
    wire [15:0] pz;
    wire mul_busy;
    wire mul_done;
    wire [15:0] mul_prod;
    reg [4:0] mul_dst_reg;
    reg wr_en;
    reg wr_wide;
    reg [4:0] wr_sel;
    reg [15:0] wr_data;
    reg [8:0] alu_res;
    reg [7:0] flags_next;
    reg [15:0] ptr;
    wire exec = ir_valid_reg && !stall_reg && !mul_busy && !mul_done; // product write-back cycle issues nothing
    wire [1:0] pc_sec = section_of(ir_pc_reg, table_first, boot_first);
    wire [1:0] z_sec = section_of({8'h00, pz}, table_first, boot_first);
    wire [1:0] z_lock = lock_of(z_sec, lock_app, lock_table, lock_boot);

    reg_file u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .rd_a_sel(rd_sel),
        .rd_b_sel(rr_sel),
        .rd_a(opa),
        .rd_b(opb),
        .ptr_x(px),
        .ptr_y(py),
        .ptr_z(pz),
        .wr_en(wr_en),
        .wr_wide(wr_wide),
        .wr_sel(wr_sel),
        .wr_data(wr_data)
    );

    mul_unit u_mul (
        .clock(clock),
        .rst_n(rst_n),
        .start(exec && op == `OP_MUL),
        .op_a(opa),
        .op_b(opb),
        .busy(mul_busy),
        .done(mul_done),
        .product(mul_prod)
    );

    always @* begin
        case (ptr_sel)
            2'd0: ptr = px;
            2'd1: ptr = py;
            default: ptr = pz;
        endcase
    end

    // fetch only through the program bus
    assign prog_addr = pc_reg;
    assign prog_rd = !(stall_reg || mul_busy || (exec && op == `OP_MUL));

    always @* begin
        alu_res = 9'h000;
        wr_en = 1'b0;
        wr_wide = 1'b0;
        wr_sel = rd_sel;
        wr_data = 16'h0000;
        flags_next = flags;
        if (load_pend_reg) begin
            wr_en = 1'b1;
            wr_wide = load_wide_reg;
            wr_sel = load_dst_reg;
            wr_data = data_rdata;
        end else if (mul_done) begin
            wr_en = 1'b1;
            wr_wide = 1'b1;
            wr_sel = mul_dst_reg;
            wr_data = mul_prod;
        end else if (exec) begin
            case (op)
                `OP_ADD: alu_res = {1'b0, opa} + {1'b0, opb};
                `OP_SUB: alu_res = {1'b0, opa} - {1'b0, opb};
                `OP_AND: alu_res = {1'b0, opa & opb};
                `OP_OR: alu_res = {1'b0, opa | opb};
                `OP_XOR: alu_res = {1'b0, opa ^ opb};
                `OP_LDI: alu_res = {1'b0, imm};
                `OP_INC: alu_res = {1'b0, opa} + 9'h001;
                default: alu_res = 9'h000;
            endcase
            if (op >= `OP_ADD && op <= `OP_INC) begin
                wr_en = 1'b1;
                wr_data = {8'h00, alu_res[7:0]};
                if (op != `OP_LDI) begin
                    // flags: bit0 carry, bit1 zero, bit2 negative
                    flags_next = {flags[7:3], alu_res[7], alu_res[7:0] == 8'h00, alu_res[8]};
                end
            end
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            pc_reg <= `RESET_VECTOR;
            ir_reg <= 32'h00000000;
            ir_valid_reg <= 1'b0;
            ir_pc_reg <= 24'h000000;
            stall_reg <= 1'b0;
        end else if (exec && op == `OP_JMP) begin
            pc_reg <= ir_reg[23:0];
            ir_valid_reg <= 1'b0;
        end else if (prog_rd) begin
            ir_reg <= prog_word;
            ir_pc_reg <= pc_reg;
            ir_valid_reg <= 1'b1;
            pc_reg <= pc_reg + 24'h000001;
            // stall while a load writes back; the op right after a load sees old data
            stall_reg <= data_rd;
        end else begin
            stall_reg <= data_rd;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            data_addr <= 24'h000000;
            data_wdata <= 16'h0000;
            data_wbytes <= 2'b00;
            data_rd <= 1'b0;
            data_wr <= 1'b0;
            data_region <= `RGN_IO;
            load_pend_reg <= 1'b0;
            load_dst_reg <= 5'h00;
            load_wide_reg <= 1'b0;
            mul_dst_reg <= 5'h00;
            prog_wr <= 1'b0;
            prog_wr_addr <= 24'h000000;
            prog_wr_data <= 16'h0000;
            prog_rd_data <= 8'h00;
            flags <= 8'h00;
            lock_fault <= 1'b0;
            io_fault <= 1'b0;
        end else begin
            data_rd <= 1'b0;
            data_wr <= 1'b0;
            prog_wr <= 1'b0;
            load_pend_reg <= data_rd;
            lock_fault <= 1'b0;
            io_fault <= 1'b0;
            flags <= flags_next;
            if (exec) begin
                case (op)
                    `OP_MUL: begin
                        mul_dst_reg <= rd_sel;
                    end
                    `OP_LDD, `OP_STD: begin
                        // extended io only through pointer forms
                        data_addr <= {8'h00, ptr};
                        data_region <= region_of({8'h00, ptr}, sram_last);
                        data_rd <= (op == `OP_LDD);
                        data_wr <= (op == `OP_STD);
                        // store sends rd, rr as one value; a wide load fills rd, rd+1
                        data_wbytes <= {imm[0], 1'b1};
                        data_wdata <= {opb, opa};
                        load_dst_reg <= rd_sel;
                        load_wide_reg <= imm[0];
                    end
                    `OP_IN, `OP_OUT: begin
                        // direct io reaches only the first 64
                        if ({16'h0000, imm} <= `IO_DIRECT_LAST) begin
                            data_addr <= {16'h0000, imm};
                            data_region <= `RGN_IO;
                            data_rd <= (op == `OP_IN);
                            data_wr <= (op == `OP_OUT);
                            data_wbytes <= 2'b01;
                            data_wdata <= {8'h00, opa};
                            load_dst_reg <= rd_sel;
                            load_wide_reg <= 1'b0;
                        end else begin
                            io_fault <= 1'b1;
                        end
                    end
                    `OP_SPS: begin
                        if (pc_sec == 2'd2 && z_sec != 2'd2 && z_lock == 2'b00) begin
                            prog_wr <= 1'b1;
                            prog_wr_addr <= {8'h00, pz};
                            prog_wr_data <= {opb, opa};
                        end else begin
                            lock_fault <= 1'b1;
                        end
                    end
                    `OP_LPM: begin
                        if (z_lock[1] && z_sec != pc_sec) begin
                            prog_rd_data <= 8'hFF;
                            lock_fault <= 1'b1;
                        end else begin
                            prog_rd_data <= pz[0] ? prog_word[15:8] : prog_word[7:0];
                        end
                    end
                    default: begin
                        data_wbytes <= data_wbytes;
                    end
                endcase
            end
        end
    end
endmodule // cpu_core

//--- tb/core_checks_assertions.sv
// assertions on the core's fetch start, data map and flash guard
`timescale 1ns/1ps
`include "core_map.vh"
module core_checks (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // program side
    input wire [23:0] prog_addr,
    input wire prog_wr,
    input wire [23:0] prog_wr_addr,
    input wire [23:0] boot_first,
    // data side
    input wire [23:0] sram_last,
    input wire [23:0] data_addr,
    input wire data_rd,
    input wire data_wr,
    input wire [2:0] data_region,
    // faults
    input wire io_fault,
    input wire lock_fault
);
    // any data access in this cycle
    wire acc = data_rd | data_wr;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    first_fetch_a: assert property (!$past(rst_n) |=> prog_addr == 24'h000001)
        else $error("second fetch address is not one");
    io_space_map_a: assert property (acc && data_addr <= 24'h000FFF |-> data_region == `RGN_IO)
        else $error("io address not decoded as io");
    eeprom_window_a: assert property (acc && data_addr[23:12] == 12'h001 |-> data_region == `RGN_EEP)
        else $error("eeprom window decoded wrongly");
    sram_start_a: assert property (acc && data_addr >= 24'h002000 && data_addr <= sram_last |-> data_region == `RGN_SRAM)
        else $error("sram address decoded wrongly");
    external_route_a: assert property (acc && data_addr > sram_last |-> data_region == `RGN_EXT)
        else $error("address above sram not external");
    io_refusal_a: assert property (io_fault |-> !acc)
        else $error("refused io access still reached the bus");
    boot_target_a: assert property (prog_wr |-> prog_wr_addr < boot_first)
        else $error("flash store into boot section");
    guard_exclusive_a: assert property (lock_fault |-> !prog_wr)
        else $error("refused flash store still written");
    addr_hold_a: assert property (!acc |-> $stable(data_addr))
        else $error("data address moved without access");
endmodule // core_checks

bind cpu_core core_checks chk (.clock, .rst_n, .prog_addr, .prog_wr, .prog_wr_addr, .boot_first,
    .sram_last, .data_addr, .data_rd, .data_wr, .data_region, .io_fault, .lock_fault);

//--- tb/mem_model.sv
// program flash and data memory on the far side of the core
`timescale 1ns/1ps
module mem_model (
    // clock
    input wire clock,
    // program bus
    input wire [23:0] prog_addr,
    input wire prog_rd,
    output wire [31:0] prog_word,
    // data bus
    input wire [23:0] data_addr,
    input wire data_rd,
    input wire data_wr,
    input wire [15:0] data_wdata,
    output reg [15:0] data_rdata
);
    logic [31:0] rom [0:255];
    logic [15:0] ram [int];
    initial data_rdata = 16'h5A5A;
    // code only from flash, own bus, garbage when not fetched
    assign prog_word = prog_rd ? rom[prog_addr[7:0]] : ~rom[prog_addr[7:0]];
    // data bus answers next cycle, toggles when idle
    always @(posedge clock) begin
        if (data_wr)
            ram[data_addr] = data_wdata;
        data_rdata <= (data_rd && ram.exists(data_addr)) ? ram[data_addr] : ~data_rdata;
    end
endmodule // mem_model

//--- tb/cpu_core_data_space_map_bench.sv
// self-checking bench for the processor core
`timescale 1ns/1ps
`include "core_map.vh"
module cpu_core_data_space_map_bench;
    typedef struct {int k; int a; int d; int r;} ev_t;
    logic clock;
    logic rst_n;
    logic [1:0] lock_app, lock_table, lock_boot;
    logic [23:0] table_first, boot_first, sram_last;
    wire [23:0] prog_addr, prog_wr_addr, data_addr;
    wire [31:0] prog_word;
    wire [15:0] prog_wr_data, data_wdata, data_rdata;
    wire [7:0] prog_rd_data, flags;
    wire [1:0] data_wbytes;
    wire [2:0] data_region;
    wire prog_rd, prog_wr, data_rd, data_wr, lock_fault, io_fault;
    int num_errors = 0;
    int samples_checked = 0;
    int regs[32];
    int pc, cyc, a, b, cf, zf, k;
    int amap[7] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000};
    int ioa[4] = '{8'h00, 8'h3F, 8'h40, 8'hFF};
    int inb[5] = '{0, 1, 1, 1, 1};
    int la[5] = '{0, 0, 1, 0, 0};
    int lt[5] = '{0, 0, 0, 2, 0};
    int tgt[5] = '{8'h10, 8'h10, 8'h10, 8'h50, 8'h90};
    ev_t eq[$];

    cpu_core uut (.clock, .rst_n, .prog_addr, .prog_rd, .prog_word, .prog_wr_addr, .prog_wr_data, .prog_wr,
        .prog_rd_data, .lock_app, .lock_table, .lock_boot, .table_first, .boot_first, .sram_last, .data_addr,
        .data_wdata, .data_wbytes, .data_rd, .data_wr, .data_region, .data_rdata, .flags, .lock_fault, .io_fault);
    mem_model mdl (.clock, .prog_addr, .prog_rd, .prog_word, .data_addr, .data_rd, .data_wr, .data_wdata,
        .data_rdata);

    // clock generation
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] ins(logic [3:0] op, int rd, int rr, int imm);
        ins = {op, rd[4:0], rr[4:0], 2'h0, imm[7:0], 8'h00};
    endfunction
    function automatic int rgn(int x);
        rgn = x <= 32'h0FFF ? `RGN_IO : x <= 32'h1FFF ? `RGN_EEP : x <= sram_last ? `RGN_SRAM : `RGN_EXT;
    endfunction
    task automatic chk(bit ok, string m);
        samples_checked++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic put(logic [31:0] w);
        mdl.rom[pc] = w;
        pc++;
    endtask
    task automatic ldi(int rd, int v);
        put(ins(`OP_LDI, rd, 0, v));
        regs[rd] = v & 255;
    endtask
    task automatic ptr(int base, int v);
        ldi(base, v & 255);
        ldi(base + 1, (v >> 8) & 255);
    endtask
    task automatic store(int rd, int rr);
        int ad;
        ad = regs[27] * 256 + regs[26];
        put(ins(`OP_STD, rd, rr, 0));
        eq.push_back('{0, ad, regs[rr] * 256 + regs[rd], rgn(ad)});
    endtask
    task automatic seen(int k, logic [23:0] ad, logic [15:0] d, logic [2:0] r);
        ev_t e;
        if (eq.size() == 0) begin
            chk(0, "unexpected bus event");
            return;
        end
        e = eq.pop_front();
        chk(k == e.k && (e.a < 0 || ad === e.a[23:0]) && (e.d < 0 || d === e.d[15:0]) && r === e.r[2:0],
            "bus event differs");
    endtask
    task automatic run(string name, int fl);
        int lp;
        int n;
        lp = pc;
        put({`OP_JMP, 4'h0, lp[23:0]});
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        chk(prog_addr === 24'h000000, "start address");
        for (n = 0; n < 300 && !(prog_addr === lp[23:0] && eq.size() == 0); n++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        chk(eq.size() == 0, "expected events missing");
        if (fl >= 0)
            chk(flags[1:0] === fl[1:0], "flags");
        $display("test %s done", name);
        for (n = 0; n < 256; n++)
            mdl.rom[n] = 32'h00000000;
        pc = 0;
        eq.delete();
        @(posedge clock);
        #1 rst_n = 1'b0;
    endtask

    // watch every strobe and fault against the queue
    always @(posedge clock) begin
        if (rst_n === 1'b1) begin
            if (data_wr !== 1'b0)
                seen(0, data_addr, data_wdata, data_region);
            if (data_rd !== 1'b0)
                seen(4, data_addr, {14'h0000, data_wbytes}, data_region);
            if (io_fault !== 1'b0)
                seen(1, 24'h000000, 16'h0000, 3'h0);
            if (lock_fault !== 1'b0)
                seen(2, 24'h000000, 16'h0000, 3'h0);
            if (prog_wr !== 1'b0)
                seen(3, prog_wr_addr, prog_wr_data, 3'h0);
        end
    end

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        lock_app = 2'h0;
        lock_table = 2'h0;
        lock_boot = 2'h0;
        table_first = 24'h000040;
        boot_first = 24'h000080;
        sram_last = `SRAM_LAST_DEF;
        pc = 0;
        cyc = 0;
        void'($urandom(46534));
        repeat (5) @(posedge clock);
        #1;
        // two-register add then store through the x pointer
        a = $urandom % 256;
        b = $urandom % 256;
        ldi(1, a);
        ldi(2, b);
        put(ins(`OP_ADD, 1, 2, 0));
        regs[1] = (a + b) & 255;
        cf = (a + b) > 255;
        zf = regs[1] == 0;
        ptr(26, 16'h2010);
        store(1, 2);
        // wide load back into then store the pair again
        put(ins(`OP_LDD, 3, 0, 1));
        eq.push_back('{4, 16'h2010, 3, `RGN_SRAM});
        regs[3] = regs[1];
        regs[4] = regs[2];
        ptr(26, 16'h2012);
        store(3, 4);
        run("alu", zf * 2 + cf);
        // multiply, product stored as a pair
        a = $urandom % 256;
        b = $urandom % 256;
        ldi(4, a);
        ldi(5, b);
        put(ins(`OP_MUL, 4, 5, 0));
        regs[4] = (a * b) & 255;
        regs[5] = (a * b) >> 8;
        ptr(26, 16'h2020);
        store(4, 5);
        run("mul", -1);
        // region boundaries of the data map
        ldi(1, $urandom % 256);
        ldi(2, $urandom % 256);
        foreach (amap[i]) begin
            ptr(26, amap[i]);
            store(1, 2);
        end
        run("map", -1);
        // direct io inside and beyond the first 64
        ldi(1, 8'hA5);
        foreach (ioa[i]) begin
            put(ins(`OP_OUT, 1, 0, ioa[i]));
            if (ioa[i] < 64)
                eq.push_back('{0, ioa[i], 8'hA5, `RGN_IO});
            else
                eq.push_back('{1, 0, -1, 0});
        end
        // direct read back of the last io byte written
        put(ins(`OP_IN, 7, 0, 8'h3F));
        eq.push_back('{4, 8'h3F, 1, `RGN_IO});
        regs[7] = 8'hA5;
        ptr(26, 16'h2030);
        store(7, 7);
        run("io", -1);
        // flash store from the app and boot sections under app and table locks
        foreach (tgt[i]) begin
            lock_app = la[i];
            lock_table = lt[i];
            ptr(30, tgt[i]);
            if (inb[i]) begin
                put({`OP_JMP, 4'h0, 24'h000080});
                pc = 128;
            end
            put(ins(`OP_SPS, 30, 31, 0));
            k = (inb[i] && la[i] == 0 && lt[i] == 0 && tgt[i] < 128) ? 3 : 2;
            eq.push_back('{k, k == 3 ? tgt[i] : -1, k == 3 ? tgt[i] : -1, 0});
            run("flash guard", -1);
        end
        finish_test();
    end
endmodule // cpu_core_data_space_map_bench
